// ===== logic/ods_pkg.sv
// shared constants and types for the octal driver serial controller
package ods_pkg;

  // apb register offsets (byte addresses)
  localparam logic [7:0] ODS_CTRL_OFS = 8'h00;
  localparam logic [7:0] ODS_CMD_OFS = 8'h04;
  localparam logic [7:0] ODS_STATUS_OFS = 8'h08;
  localparam logic [7:0] ODS_SENSE_OFS = 8'h0c;

  // control register fields
  localparam int ODS_CTRL_START_BIT = 0;
  localparam int ODS_CTRL_WIDE_BIT = 1;
  localparam logic ODS_CTRL_WIDE_RST = 1'h0;

  // status register fields
  localparam int ODS_STAT_BUSY_BIT = 0;
  localparam int ODS_STAT_SETTLED_BIT = 1;
  localparam int ODS_STAT_TRIP_BIT = 2;
  localparam int ODS_STAT_DONE_BIT = 3;

  // sense register field positions
  localparam int ODS_SENSE_LSB = 0;
  localparam int ODS_SHORT_LOW_LSB = 8;
  localparam int ODS_OFF_HIGH_LSB = 16;

  // reset values
  localparam logic [7:0] ODS_CMD_RST = 8'h00;
  localparam logic [7:0] ODS_SENSE_RST = 8'h00;

  // channel and frame sizes
  localparam int ODS_CHANNELS = 8;
  localparam int ODS_DUMMY_CLOCKS = 8;

  // timing in printed units, then in pclk cycles
  localparam int ODS_CLK_PERIOD_NS = 10;
  localparam int ODS_SCLK_MAX_KHZ = 500;
  localparam int ODS_SCLK_HALF_CYC =
    (1000000 / (2 * ODS_SCLK_MAX_KHZ) + ODS_CLK_PERIOD_NS - 1) / ODS_CLK_PERIOD_NS;
  localparam int ODS_FIRST_EDGE_NS = 3000;
  localparam int ODS_FIRST_EDGE_CYC =
    (ODS_FIRST_EDGE_NS + ODS_CLK_PERIOD_NS - 1) / ODS_CLK_PERIOD_NS;
  localparam int ODS_END_GAP_NS = 1000;
  localparam int ODS_END_GAP_CYC =
    (ODS_END_GAP_NS + ODS_CLK_PERIOD_NS - 1) / ODS_CLK_PERIOD_NS;
  localparam int ODS_REPEAT_US = 300;
  localparam int ODS_REPEAT_CYC =
    (ODS_REPEAT_US * 1000 + ODS_CLK_PERIOD_NS - 1) / ODS_CLK_PERIOD_NS;
  localparam int ODS_SETTLE_US = 50;
  localparam int ODS_SETTLE_CYC =
    (ODS_SETTLE_US * 1000 + ODS_CLK_PERIOD_NS - 1) / ODS_CLK_PERIOD_NS;

  // transfer sequencer states
  typedef enum logic [2:0] {
    ODS_IDLE,
    ODS_HOLDOFF,
    ODS_LEAD,
    ODS_CLK_LOW,
    ODS_CLK_HIGH,
    ODS_TAIL
  } ods_state_type;

endpackage

// ===== logic/ods_sync.sv
// two-flop synchroniser for signals arriving from outside pclk
`timescale 1ns/1ps
module ods_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ===== logic/ods_ctrl.sv
// apb-controlled master for an eight-channel high side driver serial port
`timescale 1ns/1ps
module ods_ctrl
  import ods_pkg::*;
#(
  parameter int SCLK_HALF = ODS_SCLK_HALF_CYC,
  parameter int FIRST_EDGE = ODS_FIRST_EDGE_CYC,
  parameter int END_GAP = ODS_END_GAP_CYC,
  parameter int REPEAT_GAP = ODS_REPEAT_CYC,
  parameter int SETTLE = ODS_SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic sclk,
  output logic sdata_out,
  output logic select_n,
  input wire logic sdata_in
);

  localparam int CW = 20;
  localparam logic [CW-1:0] SAT = {CW{1'b1}};

  ods_state_type state_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] since_rise_reg;
  logic [4:0] bit_reg;
  logic wide_reg;
  logic [7:0] cmd_reg;
  logic [7:0] sent_cmd_reg;
  logic [7:0] frame_cmd_reg;
  logic [7:0] sense_reg;
  logic [7:0] shift_reg;
  logic [7:0] frame_req_reg;
  logic settled_reg;
  logic frame_settled_reg;
  logic done_reg;
  logic ever_sent_reg;
  logic sclk_reg;
  logic sdata_out_reg;
  logic select_n_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic sdata_in_sync;
  logic access;
  logic commit;
  logic start_req;
  logic end_frame;
  logic [4:0] total_bits;
  logic [4:0] dummy_bits;
  logic [7:0] short_low;
  logic [7:0] off_high;
  logic trip;

  // device data line arrives from another domain; two flops before use
  ods_sync #(
    .WIDTH(1)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(sdata_in),
    .sync_out(sdata_in_sync)
  );

  // apb handshake: one wait cycle, then a registered answer
  assign access = psel && penable && !pready_reg;
  assign commit = psel && penable && pready_reg;
  assign start_req = commit && pwrite && (paddr == ODS_CTRL_OFS) &&
    pwdata[ODS_CTRL_START_BIT];
  assign end_frame = (state_reg == ODS_TAIL) && (cnt_reg == '0);

  // frame length: eight clocks, or eight dummies then eight in wide mode
  assign dummy_bits = wide_reg ? 5'(ODS_DUMMY_CLOCKS) : 5'h00;
  assign total_bits = dummy_bits + 5'(ODS_CHANNELS);

  // per-channel diagnosis from what was requested and what came back
  assign short_low = frame_req_reg & ~sense_reg;
  assign off_high = ~frame_req_reg & sense_reg & {8{frame_settled_reg}};
  assign trip = ((frame_req_reg ^ sense_reg) == 8'hff);

  // read mux for the register file
  function automatic logic [31:0] read_word(input logic [7:0] addr);
    logic [31:0] w;
    w = '0;
    case (addr)
      ODS_CTRL_OFS: w[ODS_CTRL_WIDE_BIT] = wide_reg;
      ODS_CMD_OFS: w[7:0] = cmd_reg;
      ODS_STATUS_OFS: begin
        w[ODS_STAT_BUSY_BIT] = (state_reg != ODS_IDLE);
        w[ODS_STAT_SETTLED_BIT] = frame_settled_reg;
        w[ODS_STAT_TRIP_BIT] = trip;
        w[ODS_STAT_DONE_BIT] = done_reg;
      end
      ODS_SENSE_OFS: begin
        w[ODS_SENSE_LSB +: 8] = sense_reg;
        w[ODS_SHORT_LOW_LSB +: 8] = short_low;
        w[ODS_OFF_HIGH_LSB +: 8] = off_high;
      end
      default: w = '0;
    endcase
    return w;
  endfunction

  // decode of mapped offsets
  function automatic logic mapped(input logic [7:0] addr);
    return (addr == ODS_CTRL_OFS) || (addr == ODS_CMD_OFS) ||
      (addr == ODS_STATUS_OFS) || (addr == ODS_SENSE_OFS);
  endfunction

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= access;
      if (access) begin
        pslverr_reg <= !mapped(paddr);
        prdata_reg <= pwrite ? 32'h00000000 : read_word(paddr);
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // software-written configuration and command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_reg <= ODS_CTRL_WIDE_RST;
      cmd_reg <= ODS_CMD_RST;
    end else if (commit && pwrite) begin
      if (paddr == ODS_CTRL_OFS) begin
        wide_reg <= pwdata[ODS_CTRL_WIDE_BIT];
      end
      if (paddr == ODS_CMD_OFS) begin
        cmd_reg <= pwdata[7:0];
      end
    end
  end

  // done flag: end of frame wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else if (end_frame) begin
      done_reg <= 1'b1;
    end else if (commit && pwrite && (paddr == ODS_STATUS_OFS) &&
        pwdata[ODS_STAT_DONE_BIT]) begin
      done_reg <= 1'b0;
    end
  end

  // time since select last rose; gates repeats and diagnostic settling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_rise_reg <= SAT;
    end else if (end_frame) begin
      since_rise_reg <= '0;
    end else if (since_rise_reg != SAT) begin
      since_rise_reg <= since_rise_reg + 1'b1;
    end
  end

  // settled once the off-state diagnostic time has passed since the command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settled_reg <= 1'b0;
    end else begin
      settled_reg <= (since_rise_reg >= CW'(SETTLE));
    end
  end

  // transfer sequencer; this end alone starts frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ODS_IDLE;
      cnt_reg <= '0;
      bit_reg <= '0;
      frame_cmd_reg <= ODS_CMD_RST;
    end else begin
      unique case (state_reg)
        ODS_IDLE: begin
          if (start_req) begin
            frame_cmd_reg <= cmd_reg;
            state_reg <= ODS_HOLDOFF;
          end
        end
        ODS_HOLDOFF: begin
          // same command again waits out the repeat spacing
          if (!ever_sent_reg || (frame_cmd_reg != sent_cmd_reg) ||
              (since_rise_reg >= CW'(REPEAT_GAP))) begin
            state_reg <= ODS_LEAD;
            cnt_reg <= CW'(FIRST_EDGE - 1);
            bit_reg <= '0;
          end
        end
        ODS_LEAD: begin
          if (cnt_reg == '0) begin
            state_reg <= ODS_CLK_LOW;
            cnt_reg <= CW'(SCLK_HALF - 1);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        ODS_CLK_LOW: begin
          if (cnt_reg == '0) begin
            state_reg <= ODS_CLK_HIGH;
            cnt_reg <= CW'(SCLK_HALF - 1);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        ODS_CLK_HIGH: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else if (bit_reg == total_bits - 5'h01) begin
            state_reg <= ODS_TAIL;
            cnt_reg <= CW'(END_GAP - 1);
          end else begin
            state_reg <= ODS_CLK_LOW;
            cnt_reg <= CW'(SCLK_HALF - 1);
            bit_reg <= bit_reg + 5'h01;
          end
        end
        ODS_TAIL: begin
          if (cnt_reg == '0) begin
            state_reg <= ODS_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        // two of the eight codes are unused; fall back to idle
        default: state_reg <= ODS_IDLE;
      endcase
    end
  end

  // serial clock idles high and drops only for each bit's low half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_reg <= 1'b1;
    end else begin
      sclk_reg <= !((state_reg == ODS_LEAD && cnt_reg == '0) ||
        (state_reg == ODS_CLK_LOW && cnt_reg != '0) ||
        (state_reg == ODS_CLK_HIGH && cnt_reg == '0 &&
         bit_reg != total_bits - 5'h01));
    end
  end

  // select low from leaving holdoff until the tail expires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_n_reg <= 1'b1;
    end else if (state_reg == ODS_HOLDOFF && state_reg != ODS_IDLE) begin
      select_n_reg <= !(!ever_sent_reg || (frame_cmd_reg != sent_cmd_reg) ||
        (since_rise_reg >= CW'(REPEAT_GAP)));
    end else if (end_frame) begin
      select_n_reg <= 1'b1;
    end
  end

  // request bit driven as the clock falls, channel one first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdata_out_reg <= 1'b0;
    end else if ((state_reg == ODS_LEAD && cnt_reg == '0) ||
        (state_reg == ODS_CLK_HIGH && cnt_reg == '0 &&
         bit_reg != total_bits - 5'h01)) begin
      // next bit index is 0 from lead, else bit_reg + 1
      if (state_reg == ODS_LEAD) begin
        sdata_out_reg <= (dummy_bits != 5'h00) ? 1'b0 : frame_cmd_reg[0];
      end else if (bit_reg + 5'h01 < dummy_bits) begin
        sdata_out_reg <= 1'b0;
      end else begin
        sdata_out_reg <= frame_cmd_reg[3'(bit_reg + 5'h01 - dummy_bits)];
      end
    end
  end

  // sense bit taken at the rising clock edge; dummy bits are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= ODS_SENSE_RST;
    end else if (state_reg == ODS_CLK_LOW && cnt_reg == '0 && bit_reg >= dummy_bits) begin
      shift_reg[3'(bit_reg - dummy_bits)] <= sdata_in_sync;
    end
  end

  // sense results published when the frame closes, settled flag as the lead starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_reg <= ODS_SENSE_RST;
      frame_req_reg <= ODS_CMD_RST;
      sent_cmd_reg <= ODS_CMD_RST;
      ever_sent_reg <= 1'b0;
      frame_settled_reg <= 1'b0;
    end else if (end_frame) begin
      sense_reg <= shift_reg;
      frame_req_reg <= sent_cmd_reg; // sense reflects the previous command
      sent_cmd_reg <= frame_cmd_reg;
      ever_sent_reg <= 1'b1;
    end else if (state_reg == ODS_LEAD && cnt_reg == CW'(FIRST_EDGE - 1)) begin
      frame_settled_reg <= settled_reg;
    end
  end

  assign sclk = sclk_reg;
  assign sdata_out = sdata_out_reg;
  assign select_n = select_n_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule

// ===== testbench/ods_ctrl_properties.sv
// port checks for the octal driver serial controller
`timescale 1ns/1ps
module ods_ctrl_checker #(
  parameter int SCLK_HALF = 4,
  parameter int FIRST_EDGE = 4,
  parameter int END_GAP = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sclk,
  input wire logic sdata_out,
  input wire logic select_n
);
  int fcnt_reg;
  int hcnt_reg;
  int ncnt_reg;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since select fell, since sclk moved, rising sclk edges in a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt_reg <= 0;
      hcnt_reg <= 0;
      ncnt_reg <= 0;
    end else begin
      fcnt_reg <= $fell(select_n) ? 0 : fcnt_reg + 1;
      hcnt_reg <= $changed(sclk) ? 0 : hcnt_reg + 1;
      ncnt_reg <= $fell(select_n) ? 0 : ncnt_reg + int'($rose(sclk));
    end
  end
  property p_first_edge;
    $fell(sclk) |-> fcnt_reg >= FIRST_EDGE - 1;
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("sclk too soon");
  property p_idle_high;
    select_n |-> sclk;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("sclk low outside frame");
  property p_sclk_rate;
    !select_n && $changed(sclk) |-> hcnt_reg >= SCLK_HALF - 1;
  endproperty
  a_sclk_rate: assert property (p_sclk_rate) else $error("sclk too fast");
  property p_end_gap;
    $rose(select_n) |-> hcnt_reg >= END_GAP - 1;
  endproperty
  a_end_gap: assert property (p_end_gap) else $error("select rose too soon");
  property p_clk_count;
    $rose(select_n) |-> ncnt_reg == 8 || ncnt_reg == 16;
  endproperty
  a_clk_count: assert property (p_clk_count) else $error("bad clock count");
  property p_data_move;
    !select_n && $changed(sdata_out) |-> $fell(sclk);
  endproperty
  a_data_move: assert property (p_data_move) else $error("data moved off fall");
  property p_apb_ready;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("bad pready");
  property p_slverr;
    pslverr |-> pready;
  endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr without pready");
endmodule

bind ods_ctrl ods_ctrl_checker #(
  .SCLK_HALF(SCLK_HALF),
  .FIRST_EDGE(FIRST_EDGE),
  .END_GAP(END_GAP)
) u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .sclk(sclk),
  .sdata_out(sdata_out),
  .select_n(select_n)
);

// ===== testbench/ods_dev_model.sv
// behavioural model of the eight-channel driver serial port
`timescale 1ns/1ps
module ods_dev_model (
  input wire logic sclk,
  input wire logic din,
  input wire logic select_n,
  input wire logic hot,
  input wire logic [7:0] short_gnd,
  input wire logic [7:0] short_vs,
  output logic dout,
  output logic [7:0] drive
);
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] in_reg = 8'h00;
  logic [7:0] diag_reg = 8'h00;
  logic trip_reg = 1'b0;
  logic bit_reg = 1'b0;
  int cnt = 0;
  // slave only: floats (shown inverted) while deselected
  assign dout = select_n ? ~bit_reg : bit_reg;
  // a trip forces every driver off
  assign drive = trip_reg ? 8'h00 : cmd_reg;
  always @(posedge hot) trip_reg = 1'b1;
  // select falling loads the diagnostics and shows the first bit at once
  always @(negedge select_n) begin
    diag_reg = trip_reg ? ~cmd_reg : (cmd_reg & ~short_gnd) | short_vs;
    cnt = 0;
    bit_reg = diag_reg[0];
  end
  // both directions move on the rising clock, channel one first
  always @(posedge sclk) begin
    if (!select_n) begin
      in_reg = {din, in_reg[7:1]};
      cnt = cnt + 1;
      bit_reg = diag_reg[cnt % 8];
    end
  end
  // select rising applies a whole-byte frame and clears a cooled trip
  always @(posedge select_n) begin
    if (cnt > 0 && cnt % 8 == 0) begin
      cmd_reg = in_reg;
      if (!hot) trip_reg = 1'b0;
    end
  end
endmodule

// ===== testbench/tb.sv
// self-checking bench for the octal driver serial controller
`timescale 1ns/1ps
module tb;
  import ods_pkg::*;
  localparam int SH = 4;
  localparam int FE = 12;
  localparam int EG = 6;
  localparam int RG = 300;
  localparam int ST = 100;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic sclk, sdata_out, select_n, sdata_in, hot, tm;
  logic [7:0] paddr, short_gnd, short_vs, drive, prev, c;
  logic [31:0] pwdata, prdata, r;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int rise_cyc = 0;
  int gap = 0;
  ods_ctrl #(.SCLK_HALF(SH), .FIRST_EDGE(FE), .END_GAP(EG), .REPEAT_GAP(RG), .SETTLE(ST))
  u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk(sclk), .sdata_out(sdata_out), .select_n(select_n), .sdata_in(sdata_in));
  ods_dev_model u_dev (.sclk(sclk), .din(sdata_out), .select_n(select_n), .hot(hot),
    .short_gnd(short_gnd), .short_vs(short_vs), .dout(sdata_in), .drive(drive));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // cycle count, hang guard and select edge times
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      mismatches = mismatches + 1;
      wrap_up();
    end
  end
  always @(posedge select_n) rise_cyc = cyc;
  always @(negedge select_n) gap = cyc - rise_cyc;
  task automatic wrap_up();
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; read data and error land in r and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one frame against the reference model of the device
  task automatic run_frame(input logic [7:0] cmd, input logic wide);
    logic [7:0] es;
    int n;
    tm = tm | hot;
    es = tm ? ~prev : (prev & ~short_gnd) | short_vs;
    apb(1'b1, ODS_CMD_OFS, {24'h0, cmd});
    apb(1'b1, ODS_CTRL_OFS, (32'(wide) << ODS_CTRL_WIDE_BIT) | 32'h1);
    n = 0;
    do begin
      apb(1'b0, ODS_STATUS_OFS, 32'h0);
      n = n + 1;
    end while (r[ODS_STAT_DONE_BIT] !== 1'b1 && n < 500);
    chk({31'h0, r[ODS_STAT_DONE_BIT]}, 32'h1);
    chk({31'h0, r[ODS_STAT_TRIP_BIT]}, {31'h0, es === ~prev});
    apb(1'b0, ODS_SENSE_OFS, 32'h0);
    chk(r, {8'h0, gap > ST ? ~prev & es : 8'h0, prev & ~es, es});
    if (!hot) tm = 1'b0;
    prev = cmd;
    chk({24'h0, drive}, {24'h0, tm ? 8'h0 : cmd});
    apb(1'b1, ODS_STATUS_OFS, 32'h1 << ODS_STAT_DONE_BIT);
    apb(1'b0, ODS_STATUS_OFS, 32'h0);
    chk(r & 32'h9, 32'h0);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    hot = 1'b0;
    short_gnd = 8'h0;
    short_vs = 8'h0;
    tm = 1'b0;
    prev = 8'h0;
    void'($urandom(32'hebc3bfb0));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then an unmapped offset
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(r, (i == 1) ? {24'h0, ODS_CMD_RST} : (i == 3) ? {24'h0, ODS_SENSE_RST} : 32'h0);
      chk({31'h0, e}, {31'h0, i == 4});
    end
    apb(1'b1, ODS_CTRL_OFS, 32'h1 << ODS_CTRL_WIDE_BIT);
    apb(1'b0, ODS_CTRL_OFS, 32'h0);
    chk(r, 32'h1 << ODS_CTRL_WIDE_BIT);
    // random frames: faults, a trip and its clearing, a quick change, a repeat
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      c = (i == 8) ? ~prev : (i == 9) ? prev : 8'($urandom);
      short_gnd <= (i == 0) ? 8'h0 : 8'($urandom & $urandom);
      short_vs <= (i == 0) ? 8'h0 : 8'($urandom & $urandom);
      hot <= (i == 5 || i == 6);
      repeat ((i == 8) ? 1 : ST + 20) @(posedge pclk);
      run_frame(c, i[0]);
      if (i == 9) chk({31'h0, gap >= RG}, 32'h1);
    end
    wrap_up();
  end
endmodule
